// File: design/rf_port_switch_control.sv
// Design decision made here: the APB register port.
`timescale 1ns/1ps
// Summary of operation
// - Single port receive closes the receive switch and keeps the PA off.
// - Single port transmit opens the receive switch and enables the shared PA.
// - Single port with output enabled drives high on transmit, low on receive.
// - The control output is high only during a CCA, receive or transmit.
// - Dual port receive uses the input pair with its PA always off.
// - Dual port transmit enables the separate output pair's PA only.
// - Dual port with output enabled shows transmit versus receive.
// - Port mode at bit 12 resets to dual port; 1 selects single port.
// - Output enable at bit 14 resets to 0 and tri-states the output.
// - Output enable at 1 drives the output from mode, polarity and operation.
// - Polarity at bit 13 acts only in dual port with the output enabled.
// - Polarity at 1 inverts the dual port sense; reset value is 0.
// - Dual port: high on transmit, low on receive; inverted when set.
// - Enabled and idle, dozing or hibernating drives low, else tri-state.
module rf_port_switch_control (
  input  wire logic                                clk,
  input  wire logic                                reset,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [11:0]                         paddr,
  input  wire logic [31:0]                         pwdata,
  input  wire logic [3:0]                          pstrb,
  output logic                                     pready,
  output logic                                     pslverr,
  output logic [31:0]                              prdata,
  input  wire rf_port_switch_pkg::radio_op_type    radio_op,
  output rf_port_switch_pkg::rf_path_type          rf_path,
  output logic                                     frontend_ctrl_out,
  output logic                                     frontend_ctrl_oe_n
);

  rf_port_switch_pkg::ctrl_fields_type ctrl_q;
  rf_port_switch_pkg::rf_path_type     rf_path_d;
  logic                                frontend_level_d;
  logic                                frontend_drive_d;
  logic [31:0]                         prdata_q;
  logic [31:0]                         read_d;
  logic                                hit_ctrl;
  logic                                hit_status;
  logic                                setup_phase;
  logic                                access_phase;

  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;
  assign hit_ctrl     = (paddr == rf_port_switch_pkg::CTRL_ADDR);
  assign hit_status   = (paddr == rf_port_switch_pkg::STATUS_ADDR);

  // Zero wait state: read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = access_phase && !(hit_ctrl || hit_status);
  assign prdata  = prdata_q;

  // Control fields; only the byte lane holding bits 14:12 matters
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q.port_mode  <= rf_port_switch_pkg::PORT_MODE_RESET;
      ctrl_q.polarity   <= rf_port_switch_pkg::POLARITY_RESET;
      ctrl_q.out_enable <= rf_port_switch_pkg::OUT_ENABLE_RESET;
    end else if (access_phase && pwrite && hit_ctrl && pstrb[1]) begin
      ctrl_q.port_mode  <= pwdata[rf_port_switch_pkg::PORT_MODE_BIT];
      ctrl_q.polarity   <= pwdata[rf_port_switch_pkg::POLARITY_BIT];
      ctrl_q.out_enable <= pwdata[rf_port_switch_pkg::OUT_ENABLE_BIT];
    end
  end

  // Read mux; unused bits read as zero
  always_comb begin
    read_d = 32'h0000_0000;
    if (hit_ctrl) begin
      read_d[rf_port_switch_pkg::PORT_MODE_BIT]  = ctrl_q.port_mode;
      read_d[rf_port_switch_pkg::POLARITY_BIT]   = ctrl_q.polarity;
      read_d[rf_port_switch_pkg::OUT_ENABLE_BIT] = ctrl_q.out_enable;
    end else if (hit_status) begin
      read_d[2:0] = rf_path;
      read_d[3]   = frontend_ctrl_out;
      read_d[4]   = ~frontend_ctrl_oe_n;
      read_d[13:8] = radio_op;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      prdata_q <= read_d;
    end
  end

  // Switch and PA steering; unknown operation codes fall back to all off
  always_comb begin
    rf_path_d = '0;
    unique case (radio_op)
      rf_port_switch_pkg::OP_CCA,
      rf_port_switch_pkg::OP_RX: begin
        rf_path_d.rx_switch_enable = 1'b1;
      end
      rf_port_switch_pkg::OP_TX: begin
        if (ctrl_q.port_mode == rf_port_switch_pkg::MODE_SINGLE) begin
          rf_path_d.shared_pa_enable = 1'b1;
        end else begin
          rf_path_d.out_pa_enable = 1'b1;
        end
      end
      rf_port_switch_pkg::OP_IDLE,
      rf_port_switch_pkg::OP_DOZE,
      rf_port_switch_pkg::OP_HIBERNATE: begin
        rf_path_d = '0;
      end
      default: begin
        rf_path_d = '0;
      end
    endcase
  end

  // Front-end control level
  always_comb begin
    frontend_drive_d = ctrl_q.out_enable;
    frontend_level_d = 1'b0;
    unique case (radio_op)
      rf_port_switch_pkg::OP_TX: begin
        if (ctrl_q.port_mode == rf_port_switch_pkg::MODE_SINGLE) begin
          frontend_level_d = 1'b1;
        end else begin
          frontend_level_d = ~ctrl_q.polarity;
        end
      end
      rf_port_switch_pkg::OP_CCA,
      rf_port_switch_pkg::OP_RX: begin
        if (ctrl_q.port_mode == rf_port_switch_pkg::MODE_SINGLE) begin
          frontend_level_d = 1'b0;
        end else begin
          frontend_level_d = ctrl_q.polarity;
        end
      end
      rf_port_switch_pkg::OP_IDLE,
      rf_port_switch_pkg::OP_DOZE,
      rf_port_switch_pkg::OP_HIBERNATE: begin
        frontend_level_d = 1'b0;
      end
      default: begin
        frontend_level_d = 1'b0;
      end
    endcase
    // Tri-stated pin carries no level, keeps the output quiet
    if (!frontend_drive_d) begin
      frontend_level_d = 1'b0;
    end
  end

  // Registered so the pins never glitch on decode changes
  always_ff @(posedge clk) begin
    if (reset) begin
      rf_path            <= '0;
      frontend_ctrl_out  <= 1'b0;
      frontend_ctrl_oe_n <= 1'b1;
    end else begin
      rf_path            <= rf_path_d;
      frontend_ctrl_out  <= frontend_level_d;
      frontend_ctrl_oe_n <= ~frontend_drive_d;
    end
  end

endmodule : rf_port_switch_control

// File: design/rf_port_switch_pkg.sv
package rf_port_switch_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  CTRL_INDEX       = 8'h07;
  localparam logic [7:0]  STATUS_INDEX     = 8'h08;
  localparam logic [11:0] CTRL_ADDR        = {2'h0, CTRL_INDEX, 2'h0};
  localparam logic [11:0] STATUS_ADDR      = {2'h0, STATUS_INDEX, 2'h0};

  // Field positions in the control register
  localparam int          PORT_MODE_BIT    = 12;
  localparam int          POLARITY_BIT     = 13;
  localparam int          OUT_ENABLE_BIT   = 14;

  // Reset values of the fields
  localparam logic        PORT_MODE_RESET  = 1'b0;
  localparam logic        POLARITY_RESET   = 1'b0;
  localparam logic        OUT_ENABLE_RESET = 1'b0;

  // Field values
  localparam logic        MODE_DUAL        = 1'b0;
  localparam logic        MODE_SINGLE      = 1'b1;

  // Radio operation reported by the sequencer, one-hot
  typedef enum logic [5:0] {
    OP_IDLE      = 6'h01,
    OP_CCA       = 6'h02,
    OP_RX        = 6'h04,
    OP_TX        = 6'h08,
    OP_DOZE      = 6'h10,
    OP_HIBERNATE = 6'h20
  } radio_op_type;

  typedef struct packed {
    logic out_enable;
    logic polarity;
    logic port_mode;
  } ctrl_fields_type;

  // Steering of the analog front end
  typedef struct packed {
    logic rx_switch_enable;
    logic shared_pa_enable;
    logic out_pa_enable;
  } rf_path_type;

endpackage : rf_port_switch_pkg

// File: tb/rf_sw_sva.sv
`timescale 1ns/1ps
module rf_sw_sva (
  input wire logic                              clk,
  input wire logic                              reset,
  input wire logic                              psel,
  input wire logic                              penable,
  input wire logic [11:0]                       paddr,
  input wire logic                              pready,
  input wire logic                              pslverr,
  input wire rf_port_switch_pkg::radio_op_type  radio_op,
  input wire rf_port_switch_pkg::rf_path_type   rf_path,
  input wire logic                              frontend_ctrl_out,
  input wire logic                              frontend_ctrl_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic acc;
  logic tx;
  assign acc = psel && penable;
  assign tx = radio_op == 6'h08;
  // Two cycles of transmit so the path flop has settled
  sequence s_tx2;
    tx [*2];
  endsequence
  a_rx_path: assert property (radio_op == 6'h04 |=> rf_path == 3'h4)
    else $error("rx path wrong");
  a_tx_path: assert property (s_tx2 |-> !rf_path.rx_switch_enable
    && (rf_path.shared_pa_enable ^ rf_path.out_pa_enable))
    else $error("tx path wrong");
  a_quiet_low: assert property (radio_op inside {6'h01, 6'h10, 6'h20}
    |=> !frontend_ctrl_out && rf_path == 3'h0) else $error("quiet not low");
  a_tri_low: assert property (frontend_ctrl_oe_n |-> !frontend_ctrl_out)
    else $error("tri-stated pin not low");
  a_outpa_tx: assert property (!tx |=> !rf_path.out_pa_enable)
    else $error("output pair amplifier on outside tx");
  a_one_pa: assert property (rf_path.shared_pa_enable |->
    !rf_path.out_pa_enable) else $error("both amplifiers on");
  a_pready_one: assert property (acc |-> pready) else $error("wait state");
  a_bad_addr: assert property (acc && paddr != 12'h01C && paddr != 12'h020
    |-> pslverr) else $error("no error on unmapped");
  a_good_addr: assert property (acc && paddr == 12'h01C |-> !pslverr)
    else $error("error on control");
endmodule : rf_sw_sva
bind rf_port_switch_control rf_sw_sva chk (.clk(clk), .reset(reset),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .radio_op(radio_op), .rf_path(rf_path),
  .frontend_ctrl_out(frontend_ctrl_out),
  .frontend_ctrl_oe_n(frontend_ctrl_oe_n));

// File: tb/fe_switch_model.sv
`timescale 1ns/1ps
module fe_switch_model (
  input wire logic  drive_level,
  input wire logic  drive_oe_n,
  output logic      tx_select
);
  // Pull-down on the net, so a released pin reads low
  assign tx_select = drive_oe_n ? 1'b0 : drive_level;
endmodule : fe_switch_model

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, prdata;
  logic [3:0]  pstrb = 4'hF;
  logic        pready, pslverr, out, oe_n, sel, er, eo;
  logic [2:0]  ep;
  rf_port_switch_pkg::radio_op_type radio_op = rf_port_switch_pkg::OP_IDLE;
  rf_port_switch_pkg::rf_path_type  rf_path;
  int          fail_count = 0, checks = 0, n;
  always #2 clk = ~clk;
  rf_port_switch_control uut (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .radio_op(radio_op), .rf_path(rf_path), .frontend_ctrl_out(out),
    .frontend_ctrl_oe_n(oe_n));
  fe_switch_model ext (.drive_level(out), .drive_oe_n(oe_n),
    .tx_select(sel));
  task test_done;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      test_done;
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : xfer
  initial begin
    repeat (20) @(posedge clk);
    reset <= 0;
    xfer(0, 12'h01C, 0);
    check(rd, 0);
    check(32'(oe_n), 1);
    xfer(0, 12'h100, 0);
    check(32'(er), 1);
    // Unmapped write must leave control at zero
    xfer(1, 12'h100, 32'h7000);
    xfer(0, 12'h01C, 0);
    check(rd, 0);
    for (int c = 0; c < 8; c++) begin
      xfer(1, 12'h01C, 32'(c) << 12);
      xfer(0, 12'h01C, 0);
      check(rd, 32'(c) << 12);
      for (int k = 0; k < 6; k++) begin
        @(posedge clk);
        radio_op <= rf_port_switch_pkg::radio_op_type'(6'h01 << k);
        repeat (2) @(posedge clk);
        #1;
        eo = c[2] & (k == 3 ? c[0] | !c[1] : (k == 1 || k == 2) & !c[0] & c[1]);
        ep = (k == 1 || k == 2) ? 3'h4 : k == 3 ? (c[0] ? 3'h2 : 3'h1) : 3'h0;
        check(32'({rf_path, out, oe_n, sel}), 32'({ep, eo, !c[2], eo}));
      end
      // Hibernate left on the sequencer input: status shows op and drive
      xfer(0, 12'h020, 0);
      check(rd, 32'h0000_2000 | (32'(c[2]) << 4));
    end
    test_done;
  end
endmodule : tb
